// file: hdl/parallel_port_pin_function_select.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - strap level in reset picks pin function
// - strap low selects general-purpose I/O
// - strap high selects memory control outputs
// - general-purpose lines are inputs after reset
// - byte enables float in reset, then 1
// - sdram clock enable floats, then drives 1
// - lines 29-33 pair with be1-3, cke, soe3
// - space-3 output enable floats, then drives 1
module parallel_port_pin_function_select (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_strap_select_input,
    input wire logic [4:0] i_pin_in,
    output logic [4:0] o_pin_out,
    output logic [4:0] o_pin_oe_b,
    output logic [4:0] o_par_io_line_in,
    output logic o_gpio_mode,
    output logic o_mem_mode
);
    ////////////////////////////////////////////////////////////////////////
    // strap and pin synchronisers: first stage feeds only the second
    logic strap_s1_q, strap_s2_q;
    logic [4:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge i_mclk) begin
        strap_s1_q <= i_strap_select_input;
        strap_s2_q <= strap_s1_q;
        pin_s1_q <= i_pin_in;
        pin_s2_q <= pin_s1_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // function state: strap tracked in reset, frozen after release
    pin_func_pkg::pin_fn_t fn_q, fn_d;
    logic strap_q, strap_d;
    always_comb begin
        fn_d = fn_q;
        strap_d = strap_q;
        if (!i_rst_b) begin
            fn_d = pin_func_pkg::FN_RESET;
            strap_d = strap_s2_q;
        end else begin
            case (fn_q)
                pin_func_pkg::FN_RESET: begin
                    // reset release: commit the sampled strap
                    fn_d = strap_q ? pin_func_pkg::FN_MEM
                                   : pin_func_pkg::FN_GPIO;
                end
                default: fn_d = fn_q;
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        fn_q <= fn_d;
        strap_q <= strap_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin pairing, bit p of every pad vector:
    //   0: line 29 / byte enable 1
    //   1: line 30 / byte enable 2
    //   2: line 31 / byte enable 3
    //   3: line 32 / sdram clock enable
    //   4: line 33 / space-3 output enable
    // modes decode fn_d so that pads and flags switch on the same edge
    // that commits the strap, one cycle after release
    logic gmode_d, mmode_d;
    always_comb begin
        gmode_d = 1'b0;
        mmode_d = 1'b0;
        if (i_rst_b) begin
            gmode_d = (fn_d == pin_func_pkg::FN_GPIO);
            mmode_d = (fn_d == pin_func_pkg::FN_MEM);
        end
    end
    always_ff @(posedge i_mclk) begin
        o_gpio_mode <= gmode_d;
        o_mem_mode <= mmode_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // pad drive, one slice per pin; oe is active low, so every pad floats
    // in reset and while its line serves as a general-purpose input
    for (genvar p = 0; p < pin_func_pkg::NUM_PINS; p++) begin : g_pad
        logic out_d, oe_b_d, gin_d;
        logic out_q, oe_b_q, gin_q;
        always_comb begin
            out_d = 1'b0;
            oe_b_d = pin_func_pkg::OE_ALL_FLOAT[p];
            gin_d = 1'b0;
            if (i_rst_b) begin
                case (fn_d)
                    pin_func_pkg::FN_MEM: begin
                        out_d = pin_func_pkg::MEM_IDLE_LEVEL[p];
                        oe_b_d = pin_func_pkg::OE_ALL_DRIVE[p];
                    end
                    pin_func_pkg::FN_GPIO: begin
                        gin_d = pin_s2_q[p];
                    end
                    default: begin
                        oe_b_d = pin_func_pkg::OE_ALL_FLOAT[p];
                    end
                endcase
            end
        end
        always_ff @(posedge i_mclk) begin
            out_q <= out_d;
            oe_b_q <= oe_b_d;
            gin_q <= gin_d;
        end
        // flops feed the pads directly, no logic after them
        assign o_pin_out[p] = out_q;
        assign o_pin_oe_b[p] = oe_b_q;
        assign o_par_io_line_in[p] = gin_q;
    end : g_pad

    ////////////////////////////////////////////////////////////////////////
    // cycles since release, saturating; lets the checks see that a role
    // chosen at release survives a long quiet stretch
    logic [7:0] held_cnt_q, held_cnt_d;
    always_comb begin
        held_cnt_d = held_cnt_q;
        if (!i_rst_b) begin
            held_cnt_d = 8'h00;
        end else if (held_cnt_q != pin_func_pkg::HELD_CNT_MAX) begin
            held_cnt_d = held_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge i_mclk) begin
        held_cnt_q <= held_cnt_d;
    end

    // edges the synchronised strap has stood still; a strap that moves in
    // the last cycles of reset may still be in the synchroniser at release
    logic [1:0] strap_age_q, strap_age_d;
    always_comb begin
        strap_age_d = strap_age_q;
        if (strap_s2_q != strap_q) begin
            strap_age_d = 2'h0;
        end else if (strap_age_q != pin_func_pkg::STRAP_SETTLE) begin
            strap_age_d = strap_age_q + 2'h1;
        end
    end
    always_ff @(posedge i_mclk) begin
        strap_age_q <= strap_age_d;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_mclk); endclocking

    // reset behaviour
    float_in_reset_a: assert property (
        !i_rst_b |=> o_pin_oe_b == 5'h1f)
        else $error("pads driven during reset");
    out_low_reset_a: assert property (
        !i_rst_b |=> o_pin_out == 5'h00 && !o_mem_mode && !o_gpio_mode)
        else $error("pad value or mode flag set during reset");

    // roles after release
    mem_drive_high_a: assert property (
        disable iff (!i_rst_b) o_mem_mode |-> o_pin_out == 5'h1f
            && o_pin_oe_b == 5'h00)
        else $error("memory controls not driven high");
    gpio_input_a: assert property (
        o_gpio_mode |-> o_pin_oe_b == 5'h1f)
        else $error("gpio line not an input");
    strap_high_a: assert property (
        !i_rst_b ##1 i_rst_b && strap_q ##1 i_rst_b |-> o_mem_mode)
        else $error("strap high did not select memory mode");
    strap_low_a: assert property (
        !i_rst_b ##1 i_rst_b && !strap_q ##1 i_rst_b |-> o_gpio_mode)
        else $error("strap low did not select gpio mode");
    release_mode_a: assert property (
        !i_rst_b ##1 i_rst_b |=> o_mem_mode || o_gpio_mode)
        else $error("no role chosen after release");
    strap_settled_a: assert property (
        !i_rst_b && strap_age_q == 2'h3 ##1 i_rst_b
            |=> o_mem_mode == $past(strap_s2_q, 2))
        else $error("committed role differs from settled strap");
    strap_frozen_a: assert property (
        disable iff (!i_rst_b) $past(i_rst_b) |-> $stable(strap_q))
        else $error("strap moved after release");
    held_role_a: assert property (
        disable iff (!i_rst_b) held_cnt_q != 8'h00
            |-> o_mem_mode || o_gpio_mode)
        else $error("role lost after release");
    mode_hold_a: assert property (
        disable iff (!i_rst_b) (o_mem_mode || o_gpio_mode)
            |=> $stable(o_mem_mode) && $stable(o_gpio_mode))
        else $error("mode changed without reset");
    soe3_high_a: assert property (
        disable iff (!i_rst_b) o_mem_mode |-> o_pin_out[4]
            && !o_pin_oe_b[4])
        else $error("space-3 output enable not high");
    be_pads_a: assert property (
        disable iff (!i_rst_b) o_mem_mode |-> o_pin_out[2:0] == 3'h7
            && o_pin_oe_b[2:0] == 3'h0)
        else $error("byte enables not driven high");
    cke_pad_a: assert property (
        disable iff (!i_rst_b) o_mem_mode |-> o_pin_out[3] && !o_pin_oe_b[3])
        else $error("sdram clock enable not driven high");
    mem_line_zero_a: assert property (
        o_mem_mode |-> o_par_io_line_in == 5'h00)
        else $error("line inputs shown in memory mode");

    // general-purpose role
    gpio_no_drive_a: assert property (
        o_gpio_mode |-> o_pin_out == 5'h00)
        else $error("pad value set in gpio mode");
    mode_excl_a: assert property (
        !(o_mem_mode && o_gpio_mode))
        else $error("both modes active");
    gpio_pass_a: assert property (
        disable iff (!i_rst_b) o_gpio_mode && $past(o_gpio_mode)
            |-> o_par_io_line_in == $past(pin_s2_q))
        else $error("gpio input not passed through");

    mem_boot_c: cover property (!i_rst_b ##1 i_rst_b ##1 o_mem_mode);
    gpio_boot_c: cover property (!i_rst_b ##1 i_rst_b ##1 o_gpio_mode);
    strap_flip_c: cover property (o_gpio_mode ##1 $changed(strap_s2_q));
    reset_in_mem_c: cover property (o_mem_mode ##1 !i_rst_b);
    late_strap_c: cover property (
        !i_rst_b && strap_age_q != 2'h3 ##1 i_rst_b);
endmodule : parallel_port_pin_function_select

// file: hdl/pin_func_pkg.sv
package pin_func_pkg;
    // number of multiplexed pins handled here
    localparam int unsigned NUM_PINS = 5;
    // pin index within the group
    localparam int unsigned IDX_LINE_29 = 0;
    localparam int unsigned IDX_LINE_30 = 1;
    localparam int unsigned IDX_LINE_31 = 2;
    localparam int unsigned IDX_LINE_32 = 3;
    localparam int unsigned IDX_LINE_33 = 4;
    // memory-interface controls drive high once out of reset
    localparam logic [4:0] MEM_IDLE_LEVEL = 5'h1f;
    // pad enables are active low: every pad released, every pad driven
    localparam logic [4:0] OE_ALL_FLOAT = 5'h1f;
    localparam logic [4:0] OE_ALL_DRIVE = 5'h00;
    // saturation points of the helper counters beside the checks
    localparam logic [7:0] HELD_CNT_MAX = 8'hff;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // function codes, one-hot
    typedef enum logic [2:0] {
        FN_RESET = 3'h1,
        FN_GPIO = 3'h2,
        FN_MEM = 3'h4
    } pin_fn_t;
endpackage : pin_func_pkg

// file: test/pad_far_side.sv
`timescale 1ns/100ps
module pad_far_side (
    input wire logic [4:0] i_pin_out,
    input wire logic [4:0] i_pin_oe_b,
    input wire logic [4:0] i_drive,
    output logic [4:0] o_pad
);
    // a released pad shows the far device's level, never the last driven one
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            o_pad[k] = i_pin_oe_b[k] ? i_drive[k] : i_pin_out[k];
        end
    end
endmodule : pad_far_side

// file: test/parallel_port_pin_function_select_tb.sv
`timescale 1ns/100ps
module parallel_port_pin_function_select_tb;
    logic i_mclk = 1'b0, rst_b = 1'b0, strap = 1'b0, gpio, mem;
    logic [4:0] drv = 5'h0, pad, out, oe_b, line_in;
    logic [15:0] row;
    int fails = 0, num_checks = 0;
    // strap, far-side pins, expected oe_b, expected line_in
    logic [15:0] rows [3] = '{16'h57f5, 16'h2bea, 16'ha800};
    initial forever #5 i_mclk = ~i_mclk;
    parallel_port_pin_function_select i_dut (.i_mclk(i_mclk),
        .i_rst_b(rst_b), .i_strap_select_input(strap), .i_pin_in(pad),
        .o_pin_out(out), .o_pin_oe_b(oe_b), .o_par_io_line_in(line_in),
        .o_gpio_mode(gpio), .o_mem_mode(mem));
    pad_far_side i_far (.i_pin_out(out), .i_pin_oe_b(oe_b), .i_drive(drv),
        .o_pad(pad));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (rows[i]) begin
            row = rows[i];
            @(negedge i_mclk);
            rst_b = 1'b0;
            strap = row[15];
            drv = row[14:10];
            repeat (5) @(negedge i_mclk);
            chk(oe_b, 5'h1f);
            rst_b = 1'b1;
            @(negedge i_mclk);
            chk({4'h0, mem}, {4'h0, row[15]});
            chk({4'h0, gpio}, {4'h0, ~row[15]});
            chk(oe_b, row[9:5]);
            if (row[15]) chk(out, pin_func_pkg::MEM_IDLE_LEVEL);
            else chk(out, 5'h00);
            repeat (3) @(negedge i_mclk);
            chk(line_in, row[4:0]);
            // strap flips after release; the chosen role must hold
            strap = ~row[15];
            repeat (4) @(negedge i_mclk);
            chk({4'h0, mem}, {4'h0, row[15]});
            chk(oe_b, row[9:5]);
            $display("test %0d done", i);
        end
        // reset in memory mode: the first edge must release every pad
        @(negedge i_mclk);
        rst_b = 1'b0;
        strap = 1'b1;
        @(negedge i_mclk);
        chk(oe_b, 5'h1f);
        chk(out, 5'h00);
        chk({3'h0, mem, gpio}, 5'h00);
        // strap high early in reset, low for the last cycles: gpio wins
        repeat (2) @(negedge i_mclk);
        strap = 1'b0;
        repeat (4) @(negedge i_mclk);
        rst_b = 1'b1;
        @(negedge i_mclk);
        chk({3'h0, mem, gpio}, 5'h01);
        chk(out, 5'h00);
        chk(line_in, 5'h0a);
        // a pad change reaches line_in after three edges, not two
        drv = 5'h13;
        repeat (2) @(negedge i_mclk);
        chk(line_in, 5'h0a);
        @(negedge i_mclk);
        chk(line_in, 5'h13);
        $display("test reset and latency done");
        wrap_up();
    end
    initial begin
        #2000;
        fails++;
        wrap_up();
    end
endmodule : parallel_port_pin_function_select_tb
